// ---- vpw_cfg.svh ----
/*
  vpw link constants: register offsets, field positions, reset values and
  symbol times in microseconds. assumes a 32-bit apb slave and a 200 mhz pclk.
*/
`ifndef VPW_CFG_SVH
`define VPW_CFG_SVH
`define VPW_US_CYC        200
`define VPW_OFF_CTRL2     12'h000
`define VPW_OFF_SVEC      12'h004
`define VPW_OFF_DATA      12'h008
`define VPW_OFF_FLAGS     12'h00c
`define VPW_CTRL_FASTRX   5
`define VPW_CTRL_TEOD     3
`define VPW_CTRL_RESET    32'h0000_0000
`define VPW_FL_RXFULL     0
`define VPW_FL_TXEMPTY    1
`define VPW_FL_EOF        2
`define VPW_FL_CRCERR     3
`define VPW_FL_INVALID    4
`define VPW_FL_TXERR      5
`define VPW_FLAGS_RESET   6'h02
`define VPW_FILT_MAX      4'hf
`define VPW_CRC_POLY      8'h1d
`define VPW_CRC_INIT      8'hff
`define VPW_CRC_GOOD      8'hc4
`define VPW_MAX_BYTES     12
`define VPW_SYNC_CYC      104
`define VPW_T_SHORT_US    64
`define VPW_T_LONG_US     128
`define VPW_T_SOF_US      200
`define VPW_T_EOD_US      200
`define VPW_T_EOF_US      280
`define VPW_T_IFS_US      20
`define VPW_T_IDLE_US     300
`define VPW_B_MIN_US      34
`define VPW_B_SHORT_US    96
`define VPW_B_LONG_US     164
`define VPW_B_EOF_US      240
`endif

// ---- vpw_pkg.sv ----
/*
  types of the vpw link block: transmit states and the packed state record.
  assumes vpw_cfg.svh for all figures.
*/
package vpw_pkg;
  typedef enum logic [3:0] {
    VPW_TX_IDLE = 4'b0001,
    VPW_TX_SOF  = 4'b0010,
    VPW_TX_BIT  = 4'b0100,
    VPW_TX_EOD  = 4'b1000
  } vpw_tx_e;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        tx_line;
    logic        smp;
    logic [3:0]  fcnt;
    logic        filt;
    logic        filt_d;
    logic [19:0] rcnt;
    logic        fast;
    logic        teod;
    logic [7:0]  txbuf;
    logic        tx_pend;
    logic [5:0]  flags;
    logic [7:0]  rxbuf;
    logic        in_frame;
    logic        eod_seen;
    logic        eof_seen;
    logic        idle;
    logic [7:0]  rx_crc;
    logic [2:0]  rx_bitn;
    logic [7:0]  rx_sh;
    logic [3:0]  rx_bytes;
    logic        sync_arm;
    logic [7:0]  scnt;
    vpw_tx_e     tst;
    logic [19:0] tcnt;
    logic [7:0]  tx_sh;
    logic [2:0]  tx_bitn;
    logic [7:0]  tx_crc;
    logic        tx_crcph;
    logic        tx_last;
    logic [3:0]  tx_bytes;
  } vpw_state_s;
endpackage : vpw_pkg

// ---- vpw_link_controller.sv ----
/*
  vpw single-wire link: receive noise filter, symbol decode, frame crc,
  transmit framing and separation-window sync, behind an apb slave.
  assumes an external transceiver: raw_tx_line high drives the bus active,
  raw_rx_line high means the bus is active; inputs synchronous to pclk.
*/
// Register access over APB and the address map were left to the implementer.
// Operation
// R1 - sample raw receive line each clock, apply counter update one step later
// R2 - filter counter counts up on high, down on low, between 0 and 15
// R3 - at 15 the filtered output sets and the counter saturates
// R4 - at 0 the filtered output clears and the counter saturates
// R5 - filtered output holds until the counter reaches the opposite end
// R6 - clean edges appear after about 15 to 16 clocks, short noise vanishes
// R7 - filtered pulses shorter than the shortest legal symbol are invalid symbols
// R8 - at most 12 bytes per frame, each sent msb first
// R9 - each sent frame holds at least one data byte plus crc
// R10 - frames start with a 200 us active start symbol outside the crc
// R11 - transmit crc x8+x4+x3+x2+1, preset ones, complemented and appended
// R12 - receive crc covers all bytes; remainder other than c4 flags crc error
// R13 - 200 us passive end-of-data sets no flag
// R14 - 280 us passive after data is end-of-frame and sets its flag
// R15 - wait 20 us more, 300 us passive in all, before a new start
// R16 - in separation wait resync to rising edge; send if written within 104 clocks
// R17 - receiver accepts a start symbol beginning during the separation period
// R18 - never send break; break while sending is a transmit error and stops
// R19 - break while receiving flags invalid, drops frame, clears fast receive
// R20 - 300 us or more passive is idle; pending message may start at once
// R21 - bits alternate active and passive, 64 or 128 us each
// R22 - logic 0 is 64 us passive or 128 us active
// R23 - logic 1 is 128 us passive or 64 us active
// R24 - durations measured on filtered signal in clocks from microsecond figures
`timescale 1ns/1ps
`default_nettype none
`include "vpw_cfg.svh"

module vpw_link_controller #(
  parameter int unsigned US_CYC = `VPW_US_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        raw_rx_line,
  output var  logic        raw_tx_line
);

  // the 20-bit run counter must hold a full idle time, and below four clocks
  // per microsecond the filter delay swallows the shortest symbols
  if (US_CYC < 4 || US_CYC * `VPW_T_IDLE_US >= 20'hfffff) begin : g_bad_us_cyc
    $error("vpw_link_controller: US_CYC out of range");
  end

  // microsecond figure to a 20-bit clock count
  function automatic logic [19:0] vpw_cyc(input int unsigned us);
    vpw_cyc = 20'(us * US_CYC);
  endfunction : vpw_cyc

  // one serial crc step, remainder msb out first
  function automatic logic [7:0] vpw_crc_step(input logic [7:0] c, input logic b);
    vpw_crc_step = {c[6:0], 1'b0} ^ ((c[7] ^ b) ? `VPW_CRC_POLY : 8'h00);
  endfunction : vpw_crc_step

  // same level and value gives the short bit
  function automatic logic [19:0] vpw_bit_len(input logic active, input logic b);
    vpw_bit_len = (active == b) ? vpw_cyc(`VPW_T_SHORT_US) : vpw_cyc(`VPW_T_LONG_US);
  endfunction : vpw_bit_len

  vpw_pkg::vpw_state_s s;
  vpw_pkg::vpw_state_s n;

  // every output is a register field of the state record
  assign prdata      = s.prdata;
  assign pready      = s.pready;
  assign pslverr     = s.pslverr;
  assign raw_tx_line = s.tx_line;

  always_comb begin
    // scratch values, cleared first so no latch is inferred
    logic        edge_seen;
    logic        rise;
    logic [19:0] meas;
    logic [5:0]  fset;
    logic [5:0]  fclr;
    logic        wr;
    logic        rd_done;
    logic        tx_go;
    logic [7:0]  crc_nx;
    logic        nbit;
    edge_seen = 1'b0;
    rise      = 1'b0;
    meas      = 20'h00000;
    fset      = 6'h00;
    fclr      = 6'h00;
    wr        = 1'b0;
    rd_done   = 1'b0;
    tx_go     = 1'b0;
    crc_nx    = 8'h00;
    nbit      = 1'b0;
    n         = s;

    // apb: one wait state, answer registered
    // a write lands only in the answer cycle, so an error answer changes nothing
    n.pready  = psel & penable & ~s.pready;
    n.pslverr = 1'b0;
    if (psel && penable && !s.pready) begin
      n.prdata = 32'h0000_0000;
      if (paddr == `VPW_OFF_CTRL2) begin
        n.prdata[`VPW_CTRL_FASTRX] = s.fast;
        n.prdata[`VPW_CTRL_TEOD]   = s.teod;
      end else if (paddr == `VPW_OFF_SVEC) begin
        if (s.flags[`VPW_FL_TXERR]) n.prdata[5:2] = 4'h6;
        else if (s.flags[`VPW_FL_INVALID]) n.prdata[5:2] = 4'h5;
        else if (s.flags[`VPW_FL_CRCERR]) n.prdata[5:2] = 4'h4;
        else if (s.flags[`VPW_FL_EOF]) n.prdata[5:2] = 4'h3;
        else if (s.flags[`VPW_FL_RXFULL]) n.prdata[5:2] = 4'h2;
        else if (s.flags[`VPW_FL_TXEMPTY]) n.prdata[5:2] = 4'h1;
      end else if (paddr == `VPW_OFF_DATA) begin
        n.prdata[7:0] = s.rxbuf;
      end else if (paddr == `VPW_OFF_FLAGS) begin
        n.prdata[5:0] = s.flags;
      end else begin
        n.pslverr = 1'b1;
      end
    end
    wr      = psel & penable & s.pready & pwrite & ~s.pslverr;
    rd_done = psel & penable & s.pready & ~pwrite & (paddr == `VPW_OFF_DATA);
    if (rd_done) fclr[`VPW_FL_RXFULL] = 1'b1;
    if (wr && paddr == `VPW_OFF_CTRL2) begin
      n.fast = pwdata[`VPW_CTRL_FASTRX];
      n.teod = pwdata[`VPW_CTRL_TEOD];
    end
    if (wr && paddr == `VPW_OFF_DATA) begin
      n.txbuf   = pwdata[7:0];
      n.tx_pend = 1'b1;
      fclr[`VPW_FL_TXEMPTY] = 1'b1;
    end
    if (wr && paddr == `VPW_OFF_FLAGS) fclr = fclr | pwdata[5:0];

    // receive filter
    // single clock: the falling-edge counter update is taken one clock later
    n.smp = raw_rx_line; // R1
    if (s.smp && s.fcnt != `VPW_FILT_MAX) n.fcnt = s.fcnt + 4'h1; // R1 R2
    else if (!s.smp && s.fcnt != 4'h0) n.fcnt = s.fcnt - 4'h1; // R2
    if (n.fcnt == `VPW_FILT_MAX) n.filt = 1'b1; // R3 R6
    else if (n.fcnt == 4'h0) n.filt = 1'b0; // R4 R5 R6
    n.filt_d = s.filt;

    // run length of the filtered level; fast receive scales it by four
    // edges are taken from the filtered level one clock late
    edge_seen = s.filt ^ s.filt_d;
    rise      = s.filt & ~s.filt_d;
    // saturate the scaled run so a long fast-mode idle never wraps to a short one
    if (s.fast && s.rcnt[19:18] != 2'b00) meas = 20'hfffff; // R24
    else if (s.fast) meas = {s.rcnt[17:0], 2'b00}; // R24
    else meas = s.rcnt; // R24
    // the run counter saturates; only the first crossing of each threshold matters
    if (edge_seen) n.rcnt = 20'h00001;
    else if (s.rcnt != 20'hfffff) n.rcnt = s.rcnt + 20'h00001;

    // passive bits end on a rise, active bits and symbols on a fall
    if (edge_seen) begin
      // a filtered pulse shorter than any legal symbol
      if (meas < vpw_cyc(`VPW_B_MIN_US)) begin
        if (s.in_frame) fset[`VPW_FL_INVALID] = 1'b1; // R7
        n.in_frame = 1'b0;
      end else if (rise) begin
        n.idle     = 1'b0;
        n.eof_seen = 1'b0;
        if (s.in_frame) begin
          nbit = (meas >= vpw_cyc(`VPW_B_SHORT_US)); // R22 R23
        end
      end else if (meas >= vpw_cyc(`VPW_B_LONG_US) && meas < vpw_cyc(`VPW_B_EOF_US)) begin
        // an active run past the break limit is no start symbol
        // start symbol accepted even inside the separation period
        n.in_frame = 1'b1; // R10 R17
        n.eod_seen = 1'b0;
        n.rx_crc   = `VPW_CRC_INIT;
        n.rx_bitn  = 3'h0;
        n.rx_bytes = 4'h0;
      end else if (s.in_frame) begin
        nbit = (meas < vpw_cyc(`VPW_B_SHORT_US)); // R22 R23
      end
      if (s.in_frame && meas >= vpw_cyc(`VPW_B_MIN_US)
          && meas < vpw_cyc(`VPW_B_LONG_US)) begin
        n.rx_sh  = {s.rx_sh[6:0], nbit}; // R8 R21
        n.rx_crc = vpw_crc_step(s.rx_crc, nbit); // R12
        n.rx_bitn = s.rx_bitn + 3'h1;
        if (s.rx_bitn == 3'h7) begin
          n.rxbuf    = {s.rx_sh[6:0], nbit};
          n.rx_bytes = s.rx_bytes + 4'h1;
          fset[`VPW_FL_RXFULL] = 1'b1;
          // a thirteenth byte overflows the frame
          if (s.rx_bytes == 4'(`VPW_MAX_BYTES)) begin
            fset[`VPW_FL_INVALID] = 1'b1; // R8
            n.in_frame = 1'b0;
          end
        end
      end
    end else if (!s.filt) begin
      if (s.in_frame && meas >= vpw_cyc(`VPW_B_LONG_US)) begin
        // end of data: no flag of its own, only the crc or invalid verdict
        n.in_frame = 1'b0; // R13
        n.eod_seen = 1'b1;
        // a partial byte, or no data byte before the crc, makes the frame invalid
        if (s.rx_bitn != 3'h0 || s.rx_bytes < 4'h2) fset[`VPW_FL_INVALID] = 1'b1;
        else if (s.rx_crc != `VPW_CRC_GOOD) fset[`VPW_FL_CRCERR] = 1'b1; // R12
      end
      if (s.eod_seen && meas >= vpw_cyc(`VPW_B_EOF_US)) begin
        n.eod_seen = 1'b0;
        n.eof_seen = 1'b1;
        fset[`VPW_FL_EOF] = 1'b1; // R14
      end
      if (meas >= vpw_cyc(`VPW_T_IDLE_US)) begin
        n.idle     = 1'b1; // R15 R20
        n.eof_seen = 1'b0;
      end
    end else if (meas >= vpw_cyc(`VPW_B_EOF_US)) begin
      // break on the bus
      // it stays true while the bus stays active, but in_frame and tst clear at once, so each flag is set only once
      if (s.in_frame) begin
        fset[`VPW_FL_INVALID] = 1'b1; // R19
        n.in_frame = 1'b0;
        n.fast     = 1'b0; // R19
      end
      if (s.tst != vpw_pkg::VPW_TX_IDLE) begin
        fset[`VPW_FL_TXERR] = 1'b1; // R18
        n.tst     = vpw_pkg::VPW_TX_IDLE;
        n.tx_line = 1'b0;
      end
    end

    // separation window: resync to a rising edge, accept late writes for 104 clocks
    // a write after the window closes waits for a fully idle bus instead
    if (rise && s.eof_seen && !s.idle) begin
      n.sync_arm = 1'b1; // R16
      n.scnt     = 8'h00;
    end else if (s.sync_arm) begin
      if (s.scnt == 8'(`VPW_SYNC_CYC)) n.sync_arm = 1'b0; // R16
      else n.scnt = s.scnt + 8'h01;
    end

    // transmit framing
    // no bitwise arbitration: a collision is only caught once it looks like a break
    // idle also needs the filtered line low, so a held bus keeps the sender off
    tx_go = s.tx_pend && ((s.idle && !s.filt) || s.sync_arm); // R16 R20
    case (s.tst)
      vpw_pkg::VPW_TX_IDLE: begin
        if (tx_go && n.tst == vpw_pkg::VPW_TX_IDLE) begin
          n.tst      = vpw_pkg::VPW_TX_SOF;
          n.tx_line  = 1'b1; // R10
          n.tcnt     = vpw_cyc(`VPW_T_SOF_US);
          // the start symbol stays outside the crc; the remainder is preset here
          n.tx_crc   = `VPW_CRC_INIT; // R11
          n.tx_sh    = s.txbuf; // R9
          n.tx_pend  = 1'b0;
          n.tx_last  = s.teod;
          n.tx_bytes = 4'h1;
          n.tx_crcph = 1'b0;
          n.tx_bitn  = 3'h0;
          fset[`VPW_FL_TXEMPTY] = 1'b1;
        end
      end
      vpw_pkg::VPW_TX_SOF: begin
        if (n.tst == vpw_pkg::VPW_TX_SOF) begin
          n.tcnt = s.tcnt - 20'h00001;
          if (s.tcnt == 20'h00001) begin
            n.tst     = vpw_pkg::VPW_TX_BIT;
            n.tx_line = 1'b0; // R21
            n.tcnt    = vpw_bit_len(1'b0, s.tx_sh[7]); // R22 R23
          end
        end
      end
      vpw_pkg::VPW_TX_BIT: begin
        if (n.tst == vpw_pkg::VPW_TX_BIT) begin
          n.tcnt = s.tcnt - 20'h00001;
          if (s.tcnt == 20'h00001) begin
            // crc byte bits go out but are not fed back into the remainder
            crc_nx    = s.tx_crcph ? s.tx_crc : vpw_crc_step(s.tx_crc, s.tx_sh[7]); // R11
            n.tx_crc  = crc_nx;
            n.tx_sh   = {s.tx_sh[6:0], 1'b0}; // R8
            n.tx_bitn = s.tx_bitn + 3'h1;
            n.tx_line = ~s.tx_line; // R21
            if (s.tx_bitn == 3'h7) begin
              if (s.tx_crcph) begin
                n.tst  = vpw_pkg::VPW_TX_EOD;
                n.tcnt = vpw_cyc(`VPW_T_EOD_US);
              end else if (s.tx_last || s.tx_bytes == 4'(`VPW_MAX_BYTES - 1)) begin
                n.tx_sh    = ~crc_nx; // R8 R11
                n.tx_crcph = 1'b1;
              end else if (s.tx_pend) begin
                n.tx_sh    = s.txbuf;
                n.tx_pend  = 1'b0;
                n.tx_last  = s.teod;
                n.tx_bytes = s.tx_bytes + 4'h1;
                fset[`VPW_FL_TXEMPTY] = 1'b1;
              end else begin
                // underrun: a frame cannot be held open, so it is abandoned
                fset[`VPW_FL_TXERR] = 1'b1;
                n.tst     = vpw_pkg::VPW_TX_IDLE;
                n.tx_line = 1'b0;
              end
            end
            if (n.tst == vpw_pkg::VPW_TX_BIT) begin
              n.tcnt = vpw_bit_len(n.tx_line, n.tx_sh[7]); // R22 R23
            end
          end
        end
      end
      vpw_pkg::VPW_TX_EOD: begin
        // own end of data; the separation wait follows from the idle measure
        n.tcnt = s.tcnt - 20'h00001;
        if (s.tcnt == 20'h00001) n.tst = vpw_pkg::VPW_TX_IDLE; // R15
      end
      default: begin
        n.tst     = vpw_pkg::VPW_TX_IDLE;
        n.tx_line = 1'b0;
      end
    endcase

    // hardware set wins over a software clear in the same cycle
    n.flags = (s.flags & ~fclr) | fset;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s       <= '0;
      s.tst   <= vpw_pkg::VPW_TX_IDLE;
      s.flags <= `VPW_FLAGS_RESET;
      // the bus counts as busy after reset until a full idle time is measured
      s.idle  <= 1'b0;
    end else begin
      s <= n;
    end
  end

endmodule : vpw_link_controller

`default_nettype wire

// ---- vpw_link_controller_sva.sv ----
/*
  checker for the vpw link: apb answer timing and transmit line symbol lengths.
  assumes raw_rx_line is the wired bus level, fed back with no delay.
*/
`timescale 1ns/1ps
`default_nettype none
module vpw_link_controller_sva #(
  parameter int unsigned US_CYC = 200
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        raw_rx_line,
  input wire logic        raw_tx_line
);
  localparam int T_S = 64 * US_CYC;
  localparam int T_L = 128 * US_CYC;
  localparam int T_SOF = 200 * US_CYC;
  localparam int T_B = 240 * US_CYC;
  logic [19:0] hi_cnt;
  logic [19:0] lo_cnt;
  logic        sof_run;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_cnt <= 20'h00000;
      lo_cnt <= 20'h00000;
      sof_run <= 1'b0;
    end else begin
      hi_cnt <= raw_tx_line ? hi_cnt + 20'h00001 : 20'h00000;
      lo_cnt <= raw_tx_line ? 20'h00000 : lo_cnt + 20'h00001;
      // only the first active run after a long passive gap may be a start symbol
      if (raw_tx_line && lo_cnt != 20'h00000) sof_run <= (lo_cnt >= T_B);
    end
  end
  a_apb_wait: assert property ((psel && !penable) |=> !pready ##1 pready)
    else $error("apb answer not after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_map: assert property (pready |-> pslverr == (paddr[11:4] != 8'h00 || paddr[1:0] != 2'h0))
    else $error("pslverr does not match address map");
  a_err_data: assert property (pslverr |-> prdata == 32'h0)
    else $error("read data not zero on error");
  a_hi_len: assert property ($fell(raw_tx_line) && !raw_rx_line |->
    hi_cnt == T_S || hi_cnt == T_L || hi_cnt == T_SOF)
    else $error("active symbol of wrong length");
  a_no_break: assert property (hi_cnt <= T_SOF)
    else $error("transmitter held bus active too long");
  a_lo_len: assert property ($rose(raw_tx_line) |->
    lo_cnt == T_S || lo_cnt == T_L || lo_cnt >= T_B)
    else $error("passive symbol of wrong length");
  a_sof_len: assert property ($fell(raw_tx_line) && !raw_rx_line |->
    (hi_cnt == T_SOF) == sof_run)
    else $error("frame start symbol length wrong");
  c_unmapped: cover property (pready && pslverr);
  c_tx_frame: cover property ($fell(raw_tx_line) && sof_run);
  c_tx_abort: cover property ($fell(raw_tx_line) && raw_rx_line);
endmodule : vpw_link_controller_sva
bind vpw_link_controller vpw_link_controller_sva #(.US_CYC(US_CYC)) chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .raw_rx_line(raw_rx_line), .raw_tx_line(raw_tx_line));
`default_nettype wire

// ---- vpw_bus_node.sv ----
/*
  far side of the link: wired bus with one more node that sends frames on command.
  assumes active dominates passive and the transceiver adds no delay.
*/
`timescale 1ns/1ps
`default_nettype none
module vpw_bus_node #(
  parameter int unsigned US_CYC = 200
) (
  input  wire logic pclk,
  input  wire logic tx_drive,
  output var  logic bus_level
);
  logic node_drive = 1'b0;
  logic glitch = 1'b0;
  assign bus_level = tx_drive | node_drive;
  // a pending glitch splits the next passive symbol with an 8-cycle spike
  task automatic sym(input logic lvl, input int n);
    if (glitch && !lvl) begin
      glitch = 1'b0;
      sym(1'b0, n / 2);
      sym(1'b1, 8);
      n = n / 2 - 8;
    end
    node_drive <= lvl;
    repeat (n) @(posedge pclk);
  endtask : sym
  task automatic send(input logic [7:0] q[$], input int s, input logic brk);
    logic lvl;
    lvl = 1'b0;
    sym(1'b1, 200 * US_CYC / s);
    foreach (q[i]) for (int k = 7; k >= 0; k--) begin
      sym(lvl, ((q[i][k] ^ lvl) ? 128 : 64) * US_CYC / s);
      lvl = !lvl;
    end
    if (brk) sym(1'b1, 250 * US_CYC);
    sym(1'b0, 325 * US_CYC);
  endtask : send
endmodule : vpw_bus_node
`default_nettype wire

// ---- vpw_link_controller_tb.sv ----
/*
  testbench: apb master, crc model and transmit decoder around the vpw link.
  assumes vpw_bus_node as the far side and a 4 clocks per microsecond scale.
*/
`timescale 1ns/1ps
`default_nettype none
`include "vpw_cfg.svh"
module vpw_link_controller_tb;
  localparam int unsigned US = 4;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rx;
  logic        tx;
  logic [31:0] rd;
  logic        err;
  logic [7:0]  q[$];
  logic        txbits[$];
  logic [15:0] got;
  logic        last_tx = 1'b0;
  int          run = 0;
  int          cyc = 0;
  int          fails = 0;
  int          total_checks = 0;
  always #2.5 pclk = !pclk;
  vpw_link_controller #(.US_CYC(US)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .raw_rx_line(rx), .raw_tx_line(tx));
  vpw_bus_node #(.US_CYC(US)) node_u (.pclk(pclk), .tx_drive(tx), .bus_level(rx));
  function automatic logic [7:0] crc8(input logic [7:0] b[$]);
    logic [7:0] c;
    c = 8'hff;
    foreach (b[i]) for (int k = 7; k >= 0; k--) c = {c[6:0], 1'b0} ^ ((c[7] ^ b[i][k]) ? 8'h1d : 8'h00);
    return c;
  endfunction : crc8
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // one idle edge first, so back-to-back calls never drive psel twice in a step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
                       input string what);
    apb(1'b0, a, 32'h0);
    check(what, e, rd & m);
  endtask : rdchk
  // transmit decoder: run lengths of the line turned back into bits
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 95000) begin
      fails++;
      report_and_stop();
    end
    if (tx !== last_tx) begin
      if (last_tx && run == 200 * US) txbits.delete();
      else if (run == 64 * US || run == 128 * US) txbits.push_back((run == 128 * US) ^ last_tx);
      run = 1;
    end else run++;
    last_tx = tx;
  end
  initial begin
    void'($urandom(9));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(`VPW_OFF_FLAGS, 32'h3f, 32'h02, "flags reset");
    rdchk(`VPW_OFF_CTRL2, 32'hffffffff, 32'h0, "control reset");
    rdchk(`VPW_OFF_SVEC, 32'h3c, 32'h04, "state vector reset");
    apb(1'b1, 12'h010, 32'h1);
    check("unmapped error", 32'h1, {31'h0, err});
    q = {8'($urandom), 8'($urandom), 8'($urandom)};
    q.push_back(~crc8(q));
    node_u.glitch = 1'b1;
    node_u.send(q, 1, 1'b0);
    rdchk(`VPW_OFF_FLAGS, 32'h1d, 32'h05, "rx good flags");
    rdchk(`VPW_OFF_DATA, 32'hff, {24'h0, q[3]}, "rx last byte");
    apb(1'b1, `VPW_OFF_FLAGS, 32'h3f);
    q[3] = q[3] ^ 8'($urandom_range(255, 1));
    node_u.send(q, 1, 1'b0);
    rdchk(`VPW_OFF_FLAGS, 32'h1c, 32'h0c, "rx bad crc flags");
    apb(1'b1, `VPW_OFF_FLAGS, 32'h3f);
    apb(1'b1, `VPW_OFF_CTRL2, 32'h20);
    q = {};
    repeat (11) q.push_back(8'($urandom));
    q.push_back(~crc8(q));
    node_u.send(q, 4, 1'b0);
    rdchk(`VPW_OFF_FLAGS, 32'h1d, 32'h05, "fast rx twelve bytes");
    apb(1'b1, `VPW_OFF_FLAGS, 32'h3f);
    node_u.send('{8'h5a}, 4, 1'b1);
    rdchk(`VPW_OFF_FLAGS, 32'h10, 32'h10, "break invalid flag");
    rdchk(`VPW_OFF_CTRL2, 32'h20, 32'h0, "break clears fast");
    apb(1'b1, `VPW_OFF_FLAGS, 32'h3f);
    node_u.sym(1'b1, 200 * US);
    node_u.sym(1'b0, 64 * US);
    node_u.sym(1'b1, 20 * US);
    node_u.sym(1'b0, 325 * US);
    rdchk(`VPW_OFF_FLAGS, 32'h10, 32'h10, "short pulse invalid");
    for (int n = 0; n < 2; n++) begin
      apb(1'b1, `VPW_OFF_FLAGS, 32'h3f);
      apb(1'b1, `VPW_OFF_CTRL2, 32'h08);
      q = {8'($urandom)};
      apb(1'b1, `VPW_OFF_DATA, {24'h0, q[0]});
      q.push_back(~crc8(q));
      do apb(1'b0, `VPW_OFF_FLAGS, 32'h0); while (rd[`VPW_FL_EOF] !== 1'b1);
      got = 16'h0;
      foreach (txbits[i]) got = {got[14:0], txbits[i]};
      check("tx bit count", 32'd16, txbits.size());
      check("tx frame bits", {16'h0, q[0], q[1]}, {16'h0, got});
    end
    apb(1'b1, `VPW_OFF_FLAGS, 32'h3f);
    apb(1'b1, `VPW_OFF_DATA, 32'($urandom_range(255, 0)));
    while (tx !== 1'b1) @(posedge pclk);
    node_u.sym(1'b1, 280 * US);
    node_u.sym(1'b0, 4);
    check("tx released", 32'h0, {31'h0, tx});
    rdchk(`VPW_OFF_FLAGS, 32'h20, 32'h20, "tx break error");
    report_and_stop();
  end
endmodule : vpw_link_controller_tb
`default_nettype wire
